// ### verilog/dsp_pkg.sv
/*
  Shared constants of the DAC serial command port: frame layout,
  register addresses, control field positions and reset values.
  Assumes nothing of its surroundings.
*/
package dsp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS  = 24;       // Bits in one frame
  localparam int RW_POS      = 23;       // Read/write flag position
  localparam int ADDR_HI     = 22;       // Address field top bit
  localparam int ADDR_LO     = 20;       // Address field low bit
  localparam int DATA_HI     = 19;       // Payload top bit
  localparam int CODE_LO     = 2;        // Code field low bit in payload
  localparam int CODE_BITS   = 18;       // Output code width
  localparam int PAY_BITS    = 20;       // Payload width
  localparam int SEG_BITS    = 6;        // Code bits decoded to segments
  localparam int SEG_COUNT   = 63;       // Segment switch controls
  localparam int LAD_BITS    = 12;       // Ladder switch bits
  localparam int CNT_BITS    = 5;        // Edge counter width

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ADR_IDLE  = 3'h0; // Idle command, no change
  localparam logic [2:0] ADR_CODE  = 3'h1; // Output code register
  localparam logic [2:0] ADR_CTRL  = 3'h2; // Control register
  localparam logic [2:0] ADR_CLR   = 3'h3; // Clear-code register
  localparam logic [2:0] ADR_SWC   = 3'h4; // Software control register

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_RBUF    = 1;        // Amplifier configuration
  localparam int CTL_CLAMP   = 2;        // Output ground clamp
  localparam int CTL_TRI     = 3;        // Output tristate
  localparam int CTL_TWOS    = 4;        // Offset binary or twos complement
  localparam int CTL_SODIS   = 5;        // Serial output disable
  localparam logic [19:0] CTL_RESET = 20'h00006; // Clamp and buffer set
  localparam logic [17:0] CODE_RESET = 18'h00000; // Zero output code
  localparam logic [19:0] PAY_RESET  = 20'h00000; // Cleared payload
  localparam logic [4:0]  CNT_FULL   = 5'h18;     // 24 edges seen
  localparam logic [4:0]  CNT_OVER   = 5'h19;     // Overrun marker

endpackage : dsp_pkg

// ### verilog/dsp_pin_sync.sv
/*
  Two-flop synchronisers for a group of asynchronous pins.
  Assumes one system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dsp_pin_sync #(
  parameter int         W       = 1,          // Number of pins
  parameter logic [W-1:0] RST_VAL = '0        // Idle level of each pin
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  // ----------------------------------------------------------------
  // Per-pin synchroniser
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_ff;                          // First stage, read only below
      // Two stages in series
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_ff     <= RST_VAL[i];
          pin_sync[i] <= RST_VAL[i];
        end
        else
        begin
          meta_ff     <= pin_in[i];
          pin_sync[i] <= meta_ff;
        end
      end
    end
  endgenerate

endmodule : dsp_pin_sync

// ### verilog/dsp_seg_decode.sv
/*
  Registered decoder from the output code to segment and ladder
  switch controls. Assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module dsp_seg_decode (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic [dsp_pkg::CODE_BITS-1:0]   code,
  output logic      [dsp_pkg::SEG_COUNT-1:0]   seg_sw_ff,
  output logic      [dsp_pkg::LAD_BITS-1:0]    ladder_sw_ff
);

  // ----------------------------------------------------------------
  // Thermometer decode of upper bits
  // ----------------------------------------------------------------
  logic [dsp_pkg::SEG_BITS-1:0] top_bits;     // Upper code bits
  assign top_bits = code[dsp_pkg::CODE_BITS-1 -: dsp_pkg::SEG_BITS];

  logic [dsp_pkg::SEG_COUNT-1:0] seg_next;    // Thermometer before register

  genvar i;
  generate
    for (i = 0; i < dsp_pkg::SEG_COUNT; i++)
    begin : g_seg
      // Segment on when upper value exceeds its index
      assign seg_next[i] = (int'(top_bits) > i);
    end
  endgenerate

  // One register for all segment controls
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      seg_sw_ff <= '0;
    else
      seg_sw_ff <= seg_next;
  end

  // ----------------------------------------------------------------
  // Direct ladder bits
  // ----------------------------------------------------------------
  // Lower bits drive the ladder unchanged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ladder_sw_ff <= '0;
    else
      ladder_sw_ff <= code[dsp_pkg::LAD_BITS-1:0];
  end

endmodule : dsp_seg_decode

// ### verilog/dsp_serial_port.sv
/*
  Serial command port of an 18-bit DAC: frame receive, decode,
  register file, pipelined readback and output update control.
  Assumes all pins are asynchronous to clk and the shift clock is
  slow enough to be sampled (several clk periods per phase).
*/
// Notes on behaviour
// - 24-bit input shifter, MSB first
// - Bit 23 flag, 22..20 address, payload
// - Address zero changes nothing
// - Write flag zero writes four registers
// - Read flag one selects readback source
// - Sync falling edge restarts frame count
// - Early sync rise discards the frame
// - Over 24 edges discards the frame
// - Valid frame applied at sync rise
// - Read data shifted out next frame
// - Serial output released when sync high
// - Readback pipelined with next command
// - Readback needs output enable, default enabled
// - Load low after write updates output
// - Upper six bits to 63 segments
// - Zero output, clamped, after reset
// - Sample input on falling shift edge
// - Load low in frame: update at rise
// - Load high: update on load fall
`timescale 1ns/1ps
module dsp_serial_port (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          sync_n,
  input  wire logic                          sclk,
  input  wire logic                          serial_in,
  input  wire logic                          load_output_n,
  output logic                               serial_out,
  output logic                               serial_out_oe,
  output logic [dsp_pkg::CODE_BITS-1:0]      dac_code_ff,
  output logic [dsp_pkg::SEG_COUNT-1:0]      seg_sw_ff,
  output logic [dsp_pkg::LAD_BITS-1:0]       ladder_sw_ff,
  output logic                               out_clamp_ff,
  output logic [dsp_pkg::PAY_BITS-1:0]       ctrl_ff,
  output logic [dsp_pkg::CODE_BITS-1:0]      clear_code_ff,
  output logic [dsp_pkg::PAY_BITS-1:0]       sw_ctrl_ff,
  output logic                               sw_ctrl_stb_ff
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] pins_s;                         // Synchronised pins
  logic       sync_n_s;                       // Frame sync, synced
  logic       sclk_s;                         // Shift clock, synced
  logic       din_s;                          // Serial input, synced
  logic       load_n_s;                       // Load input, synced
  logic       sync_n_d_ff;                    // Delayed sync
  logic       sclk_d_ff;                      // Delayed shift clock
  logic       load_n_d_ff;                    // Delayed load

  dsp_pin_sync #(
    .W       (4),
    .RST_VAL (4'hd)                           // Idle levels: sync, clock and load high
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   ({sync_n, sclk, serial_in, load_output_n}),
    .pin_sync (pins_s)
  );

  assign sync_n_s = pins_s[3];
  assign sclk_s   = pins_s[2];
  assign din_s    = pins_s[1];
  assign load_n_s = pins_s[0];

  // Previous levels for edge detection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_n_d_ff <= 1'b1;
      sclk_d_ff   <= 1'b1;                    // Clock parks high, no false edge
      load_n_d_ff <= 1'b1;
    end
    else
    begin
      sync_n_d_ff <= sync_n_s;
      sclk_d_ff   <= sclk_s;
      load_n_d_ff <= load_n_s;
    end
  end

  logic frame_start;                          // Sync falling edge
  logic frame_end;                            // Sync rising edge
  logic sclk_fall;                            // Shift clock falling in frame
  logic sclk_rise;                            // Shift clock rising in frame
  logic load_fall;                            // Load falling edge

  assign frame_start = sync_n_d_ff & ~sync_n_s;
  assign frame_end   = ~sync_n_d_ff & sync_n_s;
  assign sclk_fall   = sclk_d_ff & ~sclk_s & ~sync_n_s & ~frame_start;
  assign sclk_rise   = ~sclk_d_ff & sclk_s & ~sync_n_s & ~frame_start;
  assign load_fall   = load_n_d_ff & ~load_n_s;

  // ----------------------------------------------------------------
  // Receive shifter and edge counter
  // ----------------------------------------------------------------
  logic [dsp_pkg::FRAME_BITS-1:0] shift_ff;   // Input shifter
  logic [dsp_pkg::CNT_BITS-1:0]   cnt_ff;     // Falling edges this frame

  // Shift in MSB first on each falling edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shift_ff <= '0;
    else if (sclk_fall)
      shift_ff <= {shift_ff[dsp_pkg::FRAME_BITS-2:0], din_s};
  end

  // Count edges, saturating past a full frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else if (frame_start)
      cnt_ff <= '0;
    else if (sclk_fall && cnt_ff != dsp_pkg::CNT_OVER)
      cnt_ff <= cnt_ff + 5'h01;
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  logic                         frame_ok;     // Exactly 24 edges at rise
  logic                         rw_bit;       // Read/write flag
  logic [2:0]                   addr;         // Register address
  logic [dsp_pkg::PAY_BITS-1:0] payload;      // Data field
  logic [dsp_pkg::CODE_BITS-1:0] pay_code;    // Code part of payload
  logic                         wr_go;        // Valid write frame
  logic                         rd_go;        // Valid read frame

  assign frame_ok = frame_end && (cnt_ff == dsp_pkg::CNT_FULL);
  assign rw_bit   = shift_ff[dsp_pkg::RW_POS];
  assign addr     = shift_ff[dsp_pkg::ADDR_HI:dsp_pkg::ADDR_LO];
  assign payload  = shift_ff[dsp_pkg::DATA_HI:0];
  assign pay_code = payload[dsp_pkg::DATA_HI:dsp_pkg::CODE_LO];
  assign wr_go    = frame_ok && !rw_bit && (addr != dsp_pkg::ADR_IDLE);
  assign rd_go    = frame_ok && rw_bit && (addr != dsp_pkg::ADR_IDLE);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [dsp_pkg::CODE_BITS-1:0] input_code_ff; // Code awaiting update

  // Input code register write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      input_code_ff <= dsp_pkg::CODE_RESET;
    else if (wr_go && addr == dsp_pkg::ADR_CODE)
      input_code_ff <= pay_code;
  end

  // Control register write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_ff <= dsp_pkg::CTL_RESET;
    else if (wr_go && addr == dsp_pkg::ADR_CTRL)
      ctrl_ff <= payload;
  end

  // Clear-code register write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clear_code_ff <= dsp_pkg::CODE_RESET;
    else if (wr_go && addr == dsp_pkg::ADR_CLR)
      clear_code_ff <= pay_code;
  end

  // Software control register and its strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_ctrl_ff     <= dsp_pkg::PAY_RESET;
      sw_ctrl_stb_ff <= 1'b0;
    end
    else
    begin
      sw_ctrl_stb_ff <= wr_go && addr == dsp_pkg::ADR_SWC;
      if (wr_go && addr == dsp_pkg::ADR_SWC)
        sw_ctrl_ff <= payload;
    end
  end

  // ----------------------------------------------------------------
  // Output update and clamp
  // ----------------------------------------------------------------
  logic code_wr;                              // Code write this cycle
  assign code_wr = wr_go && addr == dsp_pkg::ADR_CODE;

  // Output code follows load input timing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dac_code_ff <= dsp_pkg::CODE_RESET;
    else if (code_wr && !load_n_s)
      dac_code_ff <= pay_code;
    else if (load_fall && sync_n_s)
      dac_code_ff <= input_code_ff;
  end

  // Clamp follows the control field
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_clamp_ff <= 1'b1;
    else
      out_clamp_ff <= ctrl_ff[dsp_pkg::CTL_CLAMP];
  end

  dsp_seg_decode u_dec (
    .clk          (clk),
    .rst_n        (rst_n),
    .code         (dac_code_ff),
    .seg_sw_ff    (seg_sw_ff),
    .ladder_sw_ff (ladder_sw_ff)
  );

  // ----------------------------------------------------------------
  // Pipelined readback
  // ----------------------------------------------------------------
  logic                           rd_pend_ff; // Read waiting for next frame
  logic [dsp_pkg::FRAME_BITS-1:0] rd_word_ff; // Word captured for readback
  logic [dsp_pkg::FRAME_BITS-1:0] out_sh_ff;  // Output shifter
  logic                           out_act_ff; // Readback running this frame
  logic [dsp_pkg::CODE_BITS-1:0]  rd_src;     // Selected source
  logic                           out_en;     // Serial output enabled

  assign out_en = ~ctrl_ff[dsp_pkg::CTL_SODIS];

  // Source select for the following readback
  always_comb
  begin
    rd_src = dsp_pkg::CODE_RESET;
    case (addr)
      dsp_pkg::ADR_CODE: rd_src = dac_code_ff;
      dsp_pkg::ADR_CLR:  rd_src = clear_code_ff;
      default:           rd_src = dsp_pkg::CODE_RESET;
    endcase
  end

  // Capture readback word at the end of a read frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_pend_ff <= 1'b0;
      rd_word_ff <= '0;
    end
    else if (rd_go)
    begin
      rd_pend_ff <= 1'b1;
      if (addr == dsp_pkg::ADR_CTRL)
        rd_word_ff <= {rw_bit, addr, ctrl_ff};
      else
        rd_word_ff <= {rw_bit, addr, rd_src, 2'h0};
    end
    else if (frame_start)
      rd_pend_ff <= 1'b0;
  end

  // Load at frame start, shift on rising edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_sh_ff  <= '0;
      out_act_ff <= 1'b0;
    end
    else if (frame_start)
    begin
      out_sh_ff  <= rd_word_ff;
      out_act_ff <= rd_pend_ff;
    end
    else if (sync_n_s)
      out_act_ff <= 1'b0;
    else if (sclk_rise)
      out_sh_ff  <= {out_sh_ff[dsp_pkg::FRAME_BITS-2:0], 1'b0};
  end

  // Registered pin drive
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      serial_out    <= out_sh_ff[dsp_pkg::FRAME_BITS-1];
      serial_out_oe <= out_act_ff && !sync_n_s && out_en;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_short_frame: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && cnt_ff < dsp_pkg::CNT_FULL) |=> $stable(ctrl_ff) && $stable(input_code_ff))
    else $error("short frame changed a register");

  chk_long_frame: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end && cnt_ff == dsp_pkg::CNT_OVER) |=> $stable(ctrl_ff) && $stable(clear_code_ff))
    else $error("long frame changed a register");

  chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && addr == dsp_pkg::ADR_CTRL) |=> ctrl_ff == $past(payload))
    else $error("control write not applied");

  chk_idle_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_ok && addr == dsp_pkg::ADR_IDLE) |=> $stable(sw_ctrl_ff) && !rd_pend_ff)
    else $error("idle command had an effect");

  chk_count_reset: assert property (@(posedge clk) disable iff (!rst_n)
    frame_start |=> cnt_ff == 5'h00)
    else $error("edge count not restarted");

  chk_idle_clock: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_n_s && !frame_end) |=> $stable(shift_ff))
    else $error("shifter moved while sync high");

  chk_oe_release: assert property (@(posedge clk) disable iff (!rst_n)
    sync_n_s |=> !serial_out_oe)
    else $error("serial output driven with sync high");

  chk_sync_update: assert property (@(posedge clk) disable iff (!rst_n)
    (code_wr && !load_n_s) |=> dac_code_ff == $past(pay_code))
    else $error("output code missed synchronous update");

  chk_async_update: assert property (@(posedge clk) disable iff (!rst_n)
    (load_fall && sync_n_s && !code_wr) |=> dac_code_ff == $past(input_code_ff))
    else $error("output code missed load update");

  chk_readback_pipe: assert property (@(posedge clk) disable iff (!rst_n)
    rd_go |=> rd_pend_ff ##0 (rd_word_ff[23:20] == {1'b1, $past(addr)}))
    else $error("readback not queued");

endmodule : dsp_serial_port

// ### testbench/dsp_host_model.sv
/*
  Behavioural host serial master for the DAC serial command port.
  Assumes callers run in step with the falling edge of clk.
*/
`timescale 1ns/1ps
module dsp_host_model (
  input  wire logic clk,           // System clock, used as time base
  input  wire logic serial_out,    // Readback data from the port
  input  wire logic serial_out_oe, // High while the port drives readback
  output logic      sync_n,        // Frame sync, active low
  output logic      sclk,          // Shift clock, parked high
  output logic      serial_in      // Serial data to the port
);

  // ----------------------------------------------------------------
  // Idle state of the link
  // ----------------------------------------------------------------
  initial
  begin
    sync_n    = 1'b1;
    sclk      = 1'b1;
    serial_in = 1'b0;
  end

  // Half a 400 ns link clock period
  task automatic half_bit;
    repeat (4) @(negedge clk);
  endtask : half_bit

  // ----------------------------------------------------------------
  // One frame of n falling edges; readback bits read z where undriven
  // ----------------------------------------------------------------
  task automatic xfer(input logic [23:0] word, input int n, output logic [23:0] rd);
    int i;
    rd     = 24'h000000;
    sync_n = 1'b0;
    half_bit();
    for (i = 0; i < n; i++)
    begin
      serial_in = (i < 24) ? word[23 - i] : 1'b0;
      half_bit();
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      rd = {rd[22:0], serial_out_oe ? serial_out : 1'bz};
      repeat (2) @(negedge clk);
      sclk = 1'b1;
    end
    half_bit();
    sync_n    = 1'b1;
    serial_in = ~serial_in;                              // Released line does not hold
    repeat (8) @(negedge clk);
  endtask : xfer

  // Shift clock toggling with sync high, data line changing
  task automatic idle_clocks(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      serial_in = ~serial_in;
      sclk      = 1'b0;
      half_bit();
      sclk      = 1'b1;
      half_bit();
    end
  endtask : idle_clocks

endmodule : dsp_host_model

// ### testbench/dac_serial_command_port_test.sv
/*
  Self-checking bench for the DAC serial command port.
  Assumes the host model drives the link; load pin driven here.
*/
`timescale 1ns/1ps
module dac_serial_command_port_test;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                            clk = 1'b0;     // 20 MHz clock
  logic                            rst_n;          // Sync reset, active low
  logic                            load_output_n;  // Load pin
  logic                            sync_n;         // Frame sync
  logic                            sclk;           // Shift clock
  logic                            serial_in;      // Serial data in
  logic                            serial_out;     // Readback data
  logic                            serial_out_oe;  // Readback enable
  logic [dsp_pkg::CODE_BITS-1:0]   dac_code_ff;    // Applied code
  logic [dsp_pkg::SEG_COUNT-1:0]   seg_sw_ff;      // Segment switches
  logic [dsp_pkg::LAD_BITS-1:0]    ladder_sw_ff;   // Ladder switches
  logic                            out_clamp_ff;   // Ground clamp
  logic [dsp_pkg::PAY_BITS-1:0]    ctrl_ff;        // Control register
  logic [dsp_pkg::CODE_BITS-1:0]   clear_code_ff;  // Clear code
  logic [dsp_pkg::PAY_BITS-1:0]    sw_ctrl_ff;     // Software control
  logic                            sw_ctrl_stb_ff; // Write pulse
  logic [23:0]                     rd;             // Last readback word
  int                              fails = 0;      // Mismatch count
  int                              n_compared = 0; // Comparison count
  int                              n_stb = 0;      // Write pulses seen

  always #25 clk = ~clk;

  // Count software control write pulses
  always @(negedge clk)
    if (sw_ctrl_stb_ff === 1'b1)
      n_stb++;

  dsp_serial_port dut_u (
    .clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk), .serial_in(serial_in),
    .load_output_n(load_output_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .dac_code_ff(dac_code_ff), .seg_sw_ff(seg_sw_ff), .ladder_sw_ff(ladder_sw_ff),
    .out_clamp_ff(out_clamp_ff), .ctrl_ff(ctrl_ff), .clear_code_ff(clear_code_ff),
    .sw_ctrl_ff(sw_ctrl_ff), .sw_ctrl_stb_ff(sw_ctrl_stb_ff)
  );

  dsp_host_model host_u (
    .clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sync_n(sync_n), .sclk(sclk), .serial_in(serial_in)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // Full 24-edge frame
  task automatic frame(input logic rw, input logic [2:0] adr, input logic [19:0] pay);
    host_u.xfer({rw, adr, pay}, 24, rd);
  endtask : frame

  // Thermometer of the top six code bits
  function automatic logic [62:0] therm(input logic [17:0] code);
    logic [63:0] t;
    t = (64'h1 << code[17:12]) - 64'h1;
    return t[62:0];
  endfunction : therm

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check(dac_code_ff, dsp_pkg::CODE_RESET);
    check(out_clamp_ff, 1'b1);
    check(ctrl_ff, dsp_pkg::CTL_RESET);
    check(clear_code_ff, 18'h00000);
    check(sw_ctrl_ff, 20'h00000);
    check(seg_sw_ff, 63'h0);
    check(serial_out_oe, 1'b0);
  endtask : t_reset

  task automatic t_writes;
    frame(1'b0, dsp_pkg::ADR_CTRL, 20'h00002);
    check(ctrl_ff, 20'h00002);
    check(out_clamp_ff, 1'b0);
    frame(1'b0, dsp_pkg::ADR_CLR, 20'habcd7);
    check(clear_code_ff, 18'h2af35);
    frame(1'b0, dsp_pkg::ADR_SWC, 20'h00010);
    check(sw_ctrl_ff, 20'h00010);
    check(n_stb, 1);
  endtask : t_writes

  // Address zero with both flag values changes nothing
  task automatic t_idle_cmd;
    frame(1'b0, dsp_pkg::ADR_IDLE, 20'hfffff);
    frame(1'b1, dsp_pkg::ADR_IDLE, 20'hfffff);
    check(ctrl_ff, 20'h00002);
    check(clear_code_ff, 18'h2af35);
    check(sw_ctrl_ff, 20'h00010);
    check(n_stb, 1);
  endtask : t_idle_cmd

  // Short and long frames refused, then a good frame with load low
  task automatic t_bad_len;
    load_output_n = 1'b0;
    host_u.xfer({1'b0, dsp_pkg::ADR_CODE, 20'hffffc}, 23, rd);
    check(dac_code_ff, 18'h00000);
    host_u.xfer({1'b0, dsp_pkg::ADR_CODE, 20'hffffc}, 25, rd);
    check(dac_code_ff, 18'h00000);
    check(clear_code_ff, 18'h2af35);
    frame(1'b0, dsp_pkg::ADR_CODE, {18'h2a5c3, 2'b00});
    check(dac_code_ff, 18'h2a5c3);
    repeat (3) @(negedge clk);
    check(seg_sw_ff, therm(18'h2a5c3));
    check(ladder_sw_ff, 12'h5c3);
    load_output_n = 1'b1;
  endtask : t_bad_len

  // Load high during the frame: update on later load fall
  task automatic t_async_load;
    frame(1'b0, dsp_pkg::ADR_CODE, {18'h15a3c, 2'b00});
    check(dac_code_ff, 18'h2a5c3);
    load_output_n = 1'b0;
    repeat (8) @(negedge clk);
    check(dac_code_ff, 18'h15a3c);
    check(seg_sw_ff, therm(18'h15a3c));
    check(ladder_sw_ff, 12'ha3c);
    load_output_n = 1'b1;
  endtask : t_async_load

  // Chained reads, each word out during the next frame
  task automatic t_readback;
    frame(1'b1, dsp_pkg::ADR_CTRL, 20'h00000);
    frame(1'b1, dsp_pkg::ADR_CODE, 20'h00000);
    check(rd, {1'b1, dsp_pkg::ADR_CTRL, 20'h00002});
    frame(1'b1, dsp_pkg::ADR_CLR, 20'h00000);
    check(rd, {1'b1, dsp_pkg::ADR_CODE, 18'h15a3c, 2'b00});
    frame(1'b0, dsp_pkg::ADR_IDLE, 20'h00000);
    check(rd, {1'b1, dsp_pkg::ADR_CLR, 18'h2af35, 2'b00});
    check(serial_out_oe, 1'b0);
  endtask : t_readback

  // Serial output disabled: nothing driven, then enabled again
  task automatic t_out_off;
    frame(1'b0, dsp_pkg::ADR_CTRL, 20'h00022);
    frame(1'b1, dsp_pkg::ADR_CTRL, 20'h00000);
    frame(1'b0, dsp_pkg::ADR_IDLE, 20'h00000);
    check(rd, 24'hzzzzzz);
    frame(1'b0, dsp_pkg::ADR_CTRL, 20'h00002);
    frame(1'b1, dsp_pkg::ADR_CTRL, 20'h00000);
    frame(1'b0, dsp_pkg::ADR_IDLE, 20'h00000);
    check(rd, {1'b1, dsp_pkg::ADR_CTRL, 20'h00002});
  endtask : t_out_off

  // Shift clocking with sync high is ignored
  task automatic t_idle_clk;
    host_u.idle_clocks(6);
    check(ctrl_ff, 20'h00002);
    check(dac_code_ff, 18'h15a3c);
    frame(1'b0, dsp_pkg::ADR_CTRL, 20'h00006);
    check(ctrl_ff, 20'h00006);
    check(out_clamp_ff, 1'b1);
  endtask : t_idle_clk

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_n         = 1'b0;
    load_output_n = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_writes();
    t_idle_cmd();
    t_bad_len();
    t_async_load();
    t_readback();
    t_out_off();
    t_idle_clk();
    wrap_up();
  end

  // Hang limit, counted as a mismatch
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end

endmodule : dac_serial_command_port_test
